// [shared/bit_test_set_pkg.sv]
// constants, field layouts and timing for the bit test / bit set datapath
package bit_test_set_pkg;

    // opcode prefix bytes and fields
    localparam logic [7:0] PFX_CB     = 8'hcb;
    localparam logic [7:0] PFX_X      = 8'hdd;
    localparam logic [7:0] PFX_Y      = 8'hfd;
    localparam logic [1:0] GRP_TEST   = 2'b01;
    localparam logic [1:0] GRP_SET    = 2'b11;
    localparam logic [2:0] CODE_MEM   = 3'b110;
    localparam logic [2:0] SLOT_FLAGS = 3'b110;

    // flag bit positions inside the flag byte
    localparam int FLAG_C  = 0;
    localparam int FLAG_N  = 1;
    localparam int FLAG_PV = 2;
    localparam int FLAG_H  = 4;
    localparam int FLAG_Z  = 6;
    localparam int FLAG_S  = 7;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_GP_LO  = 8'h00;
    localparam logic [7:0] OFS_GP_HI  = 8'h04;
    localparam logic [7:0] OFS_PTR    = 8'h08;
    localparam logic [7:0] OFS_INDEX  = 8'h0c;
    localparam logic [7:0] OFS_INSTR  = 8'h10;
    localparam logic [7:0] OFS_CTRL   = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // control and status fields
    localparam int CTRL_START  = 0;
    localparam int ST_BUSY     = 0;
    localparam int ST_DONE     = 1;
    localparam int ST_ILLEGAL  = 2;
    localparam int ST_OPND_LSB = 8;

    // reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_DATA = 32'h0000_0000;

    // t states per machine cycle, first machine cycle in the low three bits
    localparam logic [14:0] SEQ_REG      = {3'h0, 3'h0, 3'h0, 3'h4, 3'h4};
    localparam logic [14:0] SEQ_PTR_TEST = {3'h0, 3'h0, 3'h4, 3'h4, 3'h4};
    localparam logic [14:0] SEQ_PTR_SET  = {3'h0, 3'h3, 3'h4, 3'h4, 3'h4};
    localparam logic [14:0] SEQ_IDX_TEST = {3'h4, 3'h5, 3'h3, 3'h4, 3'h4};
    localparam logic [2:0]  MC_REG       = 3'h2;
    localparam logic [2:0]  MC_PTR_TEST  = 3'h3;
    localparam logic [2:0]  MC_PTR_SET   = 3'h4;
    localparam logic [2:0]  MC_IDX_TEST  = 3'h5;

    // machine cycle that reads or writes memory, and the t state that samples read data
    localparam logic [2:0] RD_MC_PTR = 3'h2;
    localparam logic [2:0] RD_MC_IDX = 3'h4;
    localparam logic [2:0] WR_MC_PTR = 3'h3;
    localparam logic [2:0] CAP_T     = 3'h2;

    // whole instruction lengths in t states (one t state is one clock)
    localparam logic [4:0] T_REG      = 5'h08;
    localparam logic [4:0] T_PTR_TEST = 5'h0c;
    localparam logic [4:0] T_PTR_SET  = 5'h0f;
    localparam logic [4:0] T_IDX_TEST = 5'h14;

    typedef enum {kind_bit_reg, kind_bit_ptr, kind_bit_idx, kind_set_reg, kind_set_ptr, kind_bad} kind_t;
    typedef enum {st_idle, st_run} exec_state_t;

endpackage

// [logic/bit_lane.sv]
// single bit pick and bit force on one operand byte
`timescale 1ns/1ps
module bit_lane #(
    parameter int WIDTH = 8
) (
    // operand and bit select
    input  wire logic [WIDTH-1:0]         data,
    input  wire logic [$clog2(WIDTH)-1:0] sel,
    // results
    output logic                          bit_val,
    output logic      [WIDTH-1:0]         set_val
);

    always_comb
    begin
        bit_val = data[sel];                        // [RQ6]
        set_val = data;
        set_val[sel] = 1'b1;                        // [RQ14]
    end

endmodule

// [logic/bit_test_set_unit.sv]
// bit test and bit set execution unit with an ahb-lite register slave
// Summary of operation
// [RQ1] bit test: zero flag is inverse of bit
// [RQ2] bit test sets half carry always
// [RQ3] bit test keeps carry flag
// [RQ4] bit test never writes its operand
// [RQ5] three bit select field picks bit binary
// [RQ6] bit zero is least significant
// [RQ7] pointer test reads memory, 4-4-4 t states
// [RQ8] index x test: dd cb d op, 20 t
// [RQ9] index y test: fd prefix, same timing
// [RQ10] register set forces bit, 4-4 t
// [RQ11] pointer set reads, forces, writes, 15 t
// [RQ12] bit set changes no flag
// [RQ13] set register opcode: cb, 11 b r
// [RQ14] memory set writes other bits unchanged
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bit_test_set_unit (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // operand memory
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata
);

    logic [7:0]  reg_bank_ff [0:7];
    logic [15:0] pointer_pair_ff;
    logic [15:0] index_x_ff;
    logic [15:0] index_y_ff;
    logic [31:0] instr_ff;
    logic        done_ff;
    logic        illegal_ff;
    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic [7:0]  bus_addr_ff;
    logic        hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] rd_mux;
    bit_test_set_pkg::exec_state_t state_ff;
    bit_test_set_pkg::kind_t kind_ff;
    logic [2:0]  mcyc_ff;
    logic [2:0]  tcnt_ff;
    logic [2:0]  sel_ff;
    logic [2:0]  slot_ff;
    logic [7:0]  opnd_ff;
    logic [15:0] mem_addr_ff;
    logic        mem_rd_ff;
    logic        mem_wr_ff;
    logic [7:0]  mem_wdata_ff;
    logic [4:0]  run_len_ff;

    bit_test_set_pkg::kind_t dec_kind;
    logic [7:0]  dec_op;
    logic [15:0] dec_addr;
    logic [14:0] seq;
    logic [2:0]  mc_count;
    logic [2:0]  cur_len;
    logic        t_last;
    logic        m_last;
    logic        finish;
    logic        busy;
    logic        addr_ok;
    logic        start;
    logic        start_ok;
    logic        tested_bit;
    logic [7:0]  set_val;
    logic        is_test;
    logic [2:0]  rd_mc;
    logic [2:0]  nxt_mcyc;

    assign busy = (state_ff == bit_test_set_pkg::st_run);

    // ahb address phase, one wait state on reads so data reflects the previous write
    assign addr_ok = hsel && htrans[1] && hready;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            bus_addr_ff  <= bit_test_set_pkg::RST_BYTE;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= bit_test_set_pkg::RST_DATA;
        end
        else
        begin
            wr_pend_ff   <= addr_ok && hwrite;
            rd_pend_ff   <= addr_ok && !hwrite;
            hreadyout_ff <= !(addr_ok && !hwrite);
            if (addr_ok)
            begin
                bus_addr_ff <= haddr[7:0];
            end
            if (rd_pend_ff)
            begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    always_comb
    begin
        case (bus_addr_ff)
            bit_test_set_pkg::OFS_GP_LO:
                rd_mux = {reg_bank_ff[3], reg_bank_ff[2], reg_bank_ff[1], reg_bank_ff[0]};
            bit_test_set_pkg::OFS_GP_HI:
                rd_mux = {reg_bank_ff[6], reg_bank_ff[7], reg_bank_ff[5], reg_bank_ff[4]};
            bit_test_set_pkg::OFS_PTR:    rd_mux = {16'h0000, pointer_pair_ff};
            bit_test_set_pkg::OFS_INDEX:  rd_mux = {index_y_ff, index_x_ff};
            bit_test_set_pkg::OFS_INSTR:  rd_mux = instr_ff;
            bit_test_set_pkg::OFS_STATUS: rd_mux = {16'h0000, opnd_ff, 5'h00, illegal_ff, done_ff, busy};
            default:                      rd_mux = 32'h0000_0000;
        endcase
    end

    // start is refused while an instruction runs
    assign start    = wr_pend_ff && (bus_addr_ff == bit_test_set_pkg::OFS_CTRL)
                      && hwdata[bit_test_set_pkg::CTRL_START] && !busy;

    // decode: cb op, or dd/fd cb disp op
    always_comb
    begin
        dec_kind = bit_test_set_pkg::kind_bad;
        dec_op   = instr_ff[15:8];
        dec_addr = pointer_pair_ff;                                                     // [RQ7]
        if (instr_ff[7:0] == bit_test_set_pkg::PFX_CB)
        begin
            if (dec_op[7:6] == bit_test_set_pkg::GRP_TEST)
                dec_kind = (dec_op[2:0] == bit_test_set_pkg::CODE_MEM) ? bit_test_set_pkg::kind_bit_ptr
                                                                       : bit_test_set_pkg::kind_bit_reg;
            else if (dec_op[7:6] == bit_test_set_pkg::GRP_SET)                          // [RQ13]
                dec_kind = (dec_op[2:0] == bit_test_set_pkg::CODE_MEM) ? bit_test_set_pkg::kind_set_ptr
                                                                       : bit_test_set_pkg::kind_set_reg;
        end
        else if ((instr_ff[7:0] == bit_test_set_pkg::PFX_X || instr_ff[7:0] == bit_test_set_pkg::PFX_Y)
                 && instr_ff[15:8] == bit_test_set_pkg::PFX_CB)
        begin
            dec_op   = instr_ff[31:24];
            // signed displacement added to the chosen index register
            dec_addr = ((instr_ff[7:0] == bit_test_set_pkg::PFX_Y) ? index_y_ff : index_x_ff)
                       + {{8{instr_ff[23]}}, instr_ff[23:16]};                           // [RQ8] [RQ9]
            if (dec_op[7:6] == bit_test_set_pkg::GRP_TEST && dec_op[2:0] == bit_test_set_pkg::CODE_MEM)
                dec_kind = bit_test_set_pkg::kind_bit_idx;
        end
    end
    assign start_ok = start && (dec_kind != bit_test_set_pkg::kind_bad);

    // machine cycle table for the running kind
    always_comb
    begin
        case (kind_ff)
            bit_test_set_pkg::kind_bit_ptr:
            begin
                seq      = bit_test_set_pkg::SEQ_PTR_TEST;                              // [RQ7]
                mc_count = bit_test_set_pkg::MC_PTR_TEST;
            end
            bit_test_set_pkg::kind_bit_idx:
            begin
                seq      = bit_test_set_pkg::SEQ_IDX_TEST;                              // [RQ8] [RQ9]
                mc_count = bit_test_set_pkg::MC_IDX_TEST;
            end
            bit_test_set_pkg::kind_set_ptr:
            begin
                seq      = bit_test_set_pkg::SEQ_PTR_SET;                               // [RQ11]
                mc_count = bit_test_set_pkg::MC_PTR_SET;
            end
            default:
            begin
                seq      = bit_test_set_pkg::SEQ_REG;                                   // [RQ10]
                mc_count = bit_test_set_pkg::MC_REG;
            end
        endcase
    end
    assign cur_len  = seq[mcyc_ff*3 +: 3];
    assign t_last   = (tcnt_ff == cur_len - 3'h1);
    assign m_last   = (mcyc_ff == mc_count - 3'h1);
    assign finish   = busy && t_last && m_last;
    assign nxt_mcyc = mcyc_ff + 3'h1;
    assign is_test  = (kind_ff == bit_test_set_pkg::kind_bit_reg) || (kind_ff == bit_test_set_pkg::kind_bit_ptr)
                      || (kind_ff == bit_test_set_pkg::kind_bit_idx);
    assign rd_mc    = (kind_ff == bit_test_set_pkg::kind_bit_idx) ? bit_test_set_pkg::RD_MC_IDX
                                                                  : bit_test_set_pkg::RD_MC_PTR;

    // sequencer: one clock per t state
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_ff <= bit_test_set_pkg::st_idle;
            kind_ff  <= bit_test_set_pkg::kind_bit_reg;
            mcyc_ff  <= 3'h0;
            tcnt_ff  <= 3'h0;
            sel_ff   <= 3'h0;
            slot_ff  <= 3'h0;
        end
        else
        begin
            case (state_ff)
                bit_test_set_pkg::st_idle:
                begin
                    if (start_ok)
                    begin
                        state_ff <= bit_test_set_pkg::st_run;
                        kind_ff  <= dec_kind;
                        mcyc_ff  <= 3'h0;
                        tcnt_ff  <= 3'h0;
                        sel_ff   <= dec_op[5:3];                                        // [RQ5]
                        slot_ff  <= dec_op[2:0];
                    end
                end
                bit_test_set_pkg::st_run:
                begin
                    if (t_last)
                    begin
                        tcnt_ff <= 3'h0;
                        if (m_last)
                            state_ff <= bit_test_set_pkg::st_idle;
                        else
                            mcyc_ff <= nxt_mcyc;
                    end
                    else
                        tcnt_ff <= tcnt_ff + 3'h1;
                end
                default:
                    state_ff <= bit_test_set_pkg::st_idle;
            endcase
        end
    end

    bit_lane #(.WIDTH(8)) u_lane (
        .data    (opnd_ff),
        .sel     (sel_ff),
        .bit_val (tested_bit),
        .set_val (set_val)
    );

    // memory strobes; tests never raise the write strobe
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            mem_addr_ff  <= bit_test_set_pkg::RST_WORD;
            mem_rd_ff    <= 1'b0;
            mem_wr_ff    <= 1'b0;
            mem_wdata_ff <= bit_test_set_pkg::RST_BYTE;
            opnd_ff      <= bit_test_set_pkg::RST_BYTE;
        end
        else
        begin
            if (start_ok)
            begin
                mem_addr_ff <= dec_addr;
                opnd_ff     <= reg_bank_ff[dec_op[2:0]];
            end
            if (busy && t_last)
            begin
                mem_rd_ff <= !m_last && (kind_ff != bit_test_set_pkg::kind_bit_reg)
                             && (kind_ff != bit_test_set_pkg::kind_set_reg) && (nxt_mcyc == rd_mc);
                mem_wr_ff <= !m_last && (kind_ff == bit_test_set_pkg::kind_set_ptr)          // [RQ4]
                             && (nxt_mcyc == bit_test_set_pkg::WR_MC_PTR);                   // [RQ11]
                mem_wdata_ff <= set_val;                                                     // [RQ14]
            end
            // sample late in the read cycle so a registered memory has settled
            if (mem_rd_ff && tcnt_ff == bit_test_set_pkg::CAP_T)
                opnd_ff <= mem_rdata;
        end
    end

    // register bank, pointer and index registers; software writes are ignored while busy
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 8; i++)
                reg_bank_ff[i] <= bit_test_set_pkg::RST_BYTE;
            pointer_pair_ff <= bit_test_set_pkg::RST_WORD;
            index_x_ff      <= bit_test_set_pkg::RST_WORD;
            index_y_ff      <= bit_test_set_pkg::RST_WORD;
            instr_ff        <= bit_test_set_pkg::RST_DATA;
        end
        else if (wr_pend_ff && !busy)
        begin
            case (bus_addr_ff)
                bit_test_set_pkg::OFS_GP_LO:
                    for (int i = 0; i < 4; i++)
                        reg_bank_ff[i] <= hwdata[i*8 +: 8];
                bit_test_set_pkg::OFS_GP_HI:
                begin
                    reg_bank_ff[4] <= hwdata[7:0];
                    reg_bank_ff[5] <= hwdata[15:8];
                    reg_bank_ff[7] <= hwdata[23:16];
                    reg_bank_ff[6] <= hwdata[31:24];
                end
                bit_test_set_pkg::OFS_PTR:   pointer_pair_ff <= hwdata[15:0];
                bit_test_set_pkg::OFS_INDEX:
                begin
                    index_x_ff <= hwdata[15:0];
                    index_y_ff <= hwdata[31:16];
                end
                bit_test_set_pkg::OFS_INSTR: instr_ff <= hwdata;
                default: ;
            endcase
        end
        else if (finish && is_test)
        begin
            // carry, sign and parity keep their old value
            reg_bank_ff[bit_test_set_pkg::SLOT_FLAGS][bit_test_set_pkg::FLAG_Z] <= !tested_bit;  // [RQ1] [RQ3]
            reg_bank_ff[bit_test_set_pkg::SLOT_FLAGS][bit_test_set_pkg::FLAG_H] <= 1'b1;         // [RQ2]
            reg_bank_ff[bit_test_set_pkg::SLOT_FLAGS][bit_test_set_pkg::FLAG_N] <= 1'b0;
        end
        else if (finish && kind_ff == bit_test_set_pkg::kind_set_reg)
            reg_bank_ff[slot_ff] <= set_val;                                            // [RQ10] [RQ12]
    end

    // status flags and busy length counter
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            done_ff    <= 1'b0;
            illegal_ff <= 1'b0;
            run_len_ff <= 5'h00;
        end
        else
        begin
            if (finish)
                done_ff <= 1'b1;
            else if (start)
                done_ff <= 1'b0;
            if (start)
                illegal_ff <= !start_ok;
            if (start_ok)
                run_len_ff <= 5'h00;
            else if (busy)
                run_len_ff <= run_len_ff + 5'h01;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign mem_addr  = mem_addr_ff;
    assign mem_rd    = mem_rd_ff;
    assign mem_wr    = mem_wr_ff;
    assign mem_wdata = mem_wdata_ff;

    property p_zero_flag;
        @(posedge clock) disable iff (!rst_n)
        finish && is_test |=> reg_bank_ff[6][6] == !$past(tested_bit);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag not inverse of tested bit"); // [RQ1]

    property p_half_carry;
        @(posedge clock) disable iff (!rst_n)
        finish && is_test |=> reg_bank_ff[6][4] && !reg_bank_ff[6][1];
    endproperty
    a_half_carry: assert property (p_half_carry) else $error("half carry not set by test"); // [RQ2]

    property p_carry_kept;
        @(posedge clock) disable iff (!rst_n)
        busy |=> $stable(reg_bank_ff[6][0]);
    endproperty
    a_carry_kept: assert property (p_carry_kept) else $error("carry changed during instruction"); // [RQ3]

    property p_test_no_write;
        @(posedge clock) disable iff (!rst_n)
        busy && is_test |-> !mem_wr_ff;
    endproperty
    a_test_no_write: assert property (p_test_no_write) else $error("write strobe during bit test"); // [RQ4]

    property p_set_reg_bit;
        @(posedge clock) disable iff (!rst_n)
        finish && kind_ff == bit_test_set_pkg::kind_set_reg |=> reg_bank_ff[$past(slot_ff)][$past(sel_ff)];
    endproperty
    a_set_reg_bit: assert property (p_set_reg_bit) else $error("selected register bit not set"); // [RQ5]

    property p_ptr_test_len;
        @(posedge clock) disable iff (!rst_n)
        $fell(busy) && kind_ff == bit_test_set_pkg::kind_bit_ptr |-> run_len_ff == 5'd12;
    endproperty
    a_ptr_test_len: assert property (p_ptr_test_len) else $error("pointer test not 12 t states"); // [RQ7]

    property p_idx_test_len;
        @(posedge clock) disable iff (!rst_n)
        $fell(busy) && kind_ff == bit_test_set_pkg::kind_bit_idx |-> run_len_ff == 5'd20;
    endproperty
    a_idx_test_len: assert property (p_idx_test_len) else $error("indexed test not 20 t states"); // [RQ8]

    property p_idx_addr;
        @(posedge clock) disable iff (!rst_n)
        $rose(busy) && kind_ff == bit_test_set_pkg::kind_bit_idx |->
            mem_addr_ff == ((instr_ff[7:0] == 8'hfd ? index_y_ff : index_x_ff) + {{8{instr_ff[23]}}, instr_ff[23:16]});
    endproperty
    a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong"); // [RQ9]

    property p_set_reg_len;
        @(posedge clock) disable iff (!rst_n)
        $fell(busy) && kind_ff == bit_test_set_pkg::kind_set_reg |-> run_len_ff == 5'd8;
    endproperty
    a_set_reg_len: assert property (p_set_reg_len) else $error("register set not 8 t states"); // [RQ10]

    property p_set_ptr_len;
        @(posedge clock) disable iff (!rst_n)
        $fell(busy) && kind_ff == bit_test_set_pkg::kind_set_ptr |-> run_len_ff == 5'd15;
    endproperty
    a_set_ptr_len: assert property (p_set_ptr_len) else $error("pointer set not 15 t states"); // [RQ11]

    property p_set_flags;
        @(posedge clock) disable iff (!rst_n)
        busy && !is_test |=> $stable(reg_bank_ff[6]);
    endproperty
    a_set_flags: assert property (p_set_flags) else $error("bit set altered flags"); // [RQ12]

    property p_write_back;
        @(posedge clock) disable iff (!rst_n)
        mem_wr_ff |-> mem_wdata_ff == (opnd_ff | (8'h01 << sel_ff));
    endproperty
    a_write_back: assert property (p_write_back) else $error("write back data wrong"); // [RQ14]

endmodule

// [tb/operand_mem.sv]
// operand memory model on the far side of the datapath
`timescale 1ns/1ps
module operand_mem (
    // clock
    input  wire logic        clock,
    // memory port
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] store [0:65535];
    logic [7:0] junk_ff = 8'h5a;
    // idle data toggles between 5a and a5, so a sample outside the read slot matches the bench's stored byte on alternate cycles
    always @(posedge clock)
        junk_ff <= ~junk_ff;
    // plain always: the bench preloads bytes directly
    always @(posedge clock)
        if (mem_wr)
            store[mem_addr] <= mem_wdata;
    assign mem_rdata = mem_rd ? store[mem_addr] : junk_ff;
endmodule

// [tb/test_bit_test_set_unit.sv]
// self-checking bench for the bit test / bit set datapath
`timescale 1ns/1ps
module test_bit_test_set_unit;
    logic        clock;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [15:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    int          miscompares;
    int          n_tests;
    bit_test_set_unit uut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    operand_mem mem (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single word transfer; only the watchdog cuts a hung wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic load(input logic [63:0] v);
        logic [31:0] q;
        bus(1'b1, bit_test_set_pkg::OFS_GP_LO, v[31:0], q);
        bus(1'b1, bit_test_set_pkg::OFS_GP_HI, v[63:32], q);
    endtask
    task automatic peek(output logic [63:0] v);
        bus(1'b0, bit_test_set_pkg::OFS_GP_LO, 32'h0, v[31:0]);
        bus(1'b0, bit_test_set_pkg::OFS_GP_HI, 32'h0, v[63:32]);
    endtask
    // strobes are sampled at each edge, so a slot that opens at edge n is seen at n+1
    task automatic run(input logic [31:0] ins, input logic [4:0] t, output int rd_at, output int wr_n,
        output logic [31:0] st);
        rd_at = 0;
        wr_n  = 0;
        bus(1'b1, bit_test_set_pkg::OFS_INSTR, ins, st);
        bus(1'b1, bit_test_set_pkg::OFS_CTRL, 32'h1, st);
        for (int k = 1; k <= t + 2; k++)
        begin
            @(posedge clock);
            if (mem_rd === 1'b1 && rd_at == 0)
                rd_at = k;
            if (mem_wr === 1'b1)
                wr_n++;
        end
        bus(1'b0, bit_test_set_pkg::OFS_STATUS, 32'h0, st);
    endtask
    task automatic t_reg();
        logic [63:0] v, g, h;
        logic [31:0] q;
        logic [2:0]  r;
        int          p, rd_at, wr_n;
        for (int b = 0; b < 8; b++)
        begin
            r = (b == 6) ? 3'h7 : 3'(b);
            p = ((r == 3'h7) ? 6 : b) * 8 + b;
            v = {(b[0] ? 8'hff : 8'h00), 56'h3c_96a5_5ac3_0ff0};
            load(v);
            run({16'h0, 2'b01, 3'(b), r, bit_test_set_pkg::PFX_CB}, bit_test_set_pkg::T_REG, rd_at, wr_n, q);
            peek(g);
            check({q[2:0], rd_at[7:0], wr_n[7:0]}, {3'b010, 16'h0});
            check(g & 64'h53ff_ffff_ffff_ffff, {1'b0, ~v[p], 2'b01, 3'b000, b[0], v[55:0]});
            run({16'h0, 2'b11, 3'(b), r, bit_test_set_pkg::PFX_CB}, bit_test_set_pkg::T_REG, rd_at, wr_n, q);
            peek(h);
            check({q[2:0], h}, {3'b010, g | (64'h1 << p)});
        end
    endtask
    task automatic t_ptr();
        logic [63:0] g, h;
        logic [31:0] q;
        logic [15:0] a;
        logic [7:0]  m;
        int          rd_at, wr_n;
        m = 8'h5a;
        for (int b = 0; b < 8; b++)
        begin
            a = 16'h4440 + 16'(b);
            mem.store[a] = m;
            load({(b[0] ? 8'hff : 8'h00), 56'h0});
            bus(1'b1, bit_test_set_pkg::OFS_PTR, {16'h0, a}, q);
            run({16'h0, 2'b01, 3'(b), 3'b110, bit_test_set_pkg::PFX_CB}, bit_test_set_pkg::T_PTR_TEST, rd_at, wr_n, q);
            peek(g);
            check({q[2:0], rd_at[7:0], wr_n[7:0], mem_addr, mem.store[a]}, {3'b010, 8'd9, 8'd0, a, m});
            check(g[63:56] & 8'h53, {1'b0, ~m[b], 2'b01, 3'b000, b[0]});
            run({16'h0, 2'b11, 3'(b), 3'b110, bit_test_set_pkg::PFX_CB}, bit_test_set_pkg::T_PTR_SET, rd_at, wr_n, q);
            peek(h);
            check({q[2:0], rd_at[7:0], wr_n[7:0], mem.store[a]}, {3'b010, 8'd9, 8'd3, m | (8'h1 << b)});
            check(h, g);
        end
    endtask
    // both index registers, negative and positive displacement
    task automatic t_idx();
        logic [63:0] g;
        logic [31:0] q;
        logic [15:0] a;
        logic [7:0]  d, m;
        int          rd_at, wr_n;
        m = 8'ha5;
        bus(1'b1, bit_test_set_pkg::OFS_INDEX, 32'h3000_2000, q);
        for (int b = 0; b < 8; b++)
        begin
            d = b[0] ? 8'h04 : 8'hfc;
            a = (b[0] ? 16'h3000 : 16'h2000) + {{8{d[7]}}, d};
            mem.store[a] = m;
            load({(b[1] ? 8'hff : 8'h00), 56'h0});
            run({2'b01, 3'(b), 3'b110, d, bit_test_set_pkg::PFX_CB,
                (b[0] ? bit_test_set_pkg::PFX_Y : bit_test_set_pkg::PFX_X)}, bit_test_set_pkg::T_IDX_TEST, rd_at, wr_n, q);
            peek(g);
            check({q[2:0], rd_at[7:0], wr_n[7:0], mem_addr, mem.store[a]}, {3'b010, 8'd17, 8'd0, a, m});
            check(g[63:56] & 8'h53, {1'b0, ~m[b], 2'b01, 3'b000, b[1]});
        end
    endtask
    // indexed set is refused, writes during a run are ignored, unmapped space reads zero
    task automatic t_bad();
        logic [63:0] g;
        logic [31:0] q;
        int          rd_at, wr_n;
        run({2'b11, 3'h2, 3'b110, 8'h00, bit_test_set_pkg::PFX_CB, bit_test_set_pkg::PFX_X}, 5'h14, rd_at, wr_n, q);
        check({q[2], q[0], rd_at[7:0], wr_n[7:0]}, {2'b10, 16'h0});
        load(64'h0000_0000_1111_2222);
        bus(1'b1, bit_test_set_pkg::OFS_INSTR, {16'h0, 8'hc7, bit_test_set_pkg::PFX_CB}, q);
        bus(1'b1, bit_test_set_pkg::OFS_CTRL, 32'h1, q);
        bus(1'b1, bit_test_set_pkg::OFS_GP_HI, 32'hffff_ffff, q);
        bus(1'b0, bit_test_set_pkg::OFS_STATUS, 32'h0, q);
        check(q[0], 1'b1);
        repeat (8) @(posedge clock);
        peek(g);
        check(g, 64'h0001_0000_1111_2222);
        bus(1'b1, 8'h1c, 32'hffff_ffff, q);
        bus(1'b0, 8'h1c, 32'h0, q);
        check({q, hresp}, 33'h0);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // the whole run needs under two thousand cycles; this allows twenty thousand
    initial
    begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        miscompares = 0;
        n_tests = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reg();
        t_ptr();
        t_idx();
        t_bad();
        print_verdict();
    end
endmodule
